/* File: rtl/serial_framed_pwm_bank48.sv */
// 48-channel 12-bit PWM bank loaded by a cascadable serial frame port.
// Serial clock and PWM clock arrive as pins and are sampled by i_mclk;
// both must stay below a quarter of the i_mclk rate.
`timescale 1ns/10ps
// Behaviour
// - Output high while PWM counter is below the channel's active value.
// - PWM counter free-runs over 4096 clocks; period starts at zero.
// - Serial clock and PWM clock are unrelated; each is sampled separately.
// - Data input enters a 584-bit shift register; last stage drives data output.
// - Serial clock output is a buffered copy of serial clock input.
// - Frame is 48 twelve-bit fields then 8-bit command, MSB and top channel first.
// - Strobe rise decodes and executes the command in the low eight stages.
// - Strobe rise with an update command loads trim multiplier results into the staging latches.
// - Strobe high loads the status frame into the shift register.
// - Strobe high over 50 us turns outputs off and resets the chip.
// - Command frame shifts in while previous status frame shifts out.
// - Eight command codes; two of them update the output widths.
// - Trimmed width is field times 2/3 times (trim+32)/64.
// - Toggle command inverts the bypass flag; bypass stores unscaled; clear at reset.
// - Sync update stages at strobe, goes active at next period start.
// - Async update goes straight to the active latches at strobe rise.
// - Outputs stay low after reset until an output enable or self test command.
// - Serial data output is low once reset releases.
// - Enabling disabled outputs restarts the PWM period at that frame.
// - One 6-bit trim factor per channel, loaded by the trim frame.
// - Status frame holds command nibble, four flags, open bits and trims.
// - Framing error on strobe with serial clock, or off a 584-bit boundary.
// - First serial clock after strobe falls is bit one of a frame.
// - Self test pulses each output for 64 PWM clocks and samples sense.
module serial_framed_pwm_bank48
   import pwm_bank_pkg::*;
(
   input  wire logic                       i_mclk,
   input  wire logic                       i_arst_n,
   input  wire logic                       i_serial_clock_in,
   input  wire logic                       i_serial_data_input,
   input  wire logic                       i_latch_reset_strobe,
   input  wire logic                       i_pwm_clock_in,
   input  wire logic                       i_open_string_sense,
   output logic                            o_serial_clock_out,
   output logic                            o_serial_data_output,
   output logic [pwm_bank_pkg::CH_NUM-1:0] o_pwm,
   input  wire logic                       i_wb_cyc,
   input  wire logic                       i_wb_stb,
   input  wire logic                       i_wb_we,
   input  wire logic [pwm_bank_pkg::ADR_W-1:0] i_wb_adr,
   input  wire logic [3:0]                 i_wb_sel,
   input  wire logic [31:0]                i_wb_dat,
   output logic [31:0]                     o_wb_dat,
   output logic                            o_wb_ack
);
   import pwm_bank_pkg::*;

   localparam logic [BITCNT_W-1:0] LAST_BIT  = BITCNT_W'(FRAME_BITS - 1);
   localparam logic [BLANK_W-1:0]  BLANK_TOP = BLANK_W'(BLANK_CYC);
   localparam logic [CH_W-1:0]     CNT_MAX   = '1;
   localparam logic [5:0]          TEST_LAST = 6'(TEST_PULSE - 1);
   localparam logic [5:0]          LAST_CH   = 6'(CH_NUM - 1);

   logic [PIN_NUM-1:0] pins_s;
   logic sck_s, sdi_s, strb_s, pck_s, sense_s;
   logic sck_prev, strb_prev, pck_prev;
   logic sck_rise, strb_rise, pwm_rise;

   // Separate samplers per pin: the two clocks are unrelated
   pin_sync #(.W(PIN_NUM)) u_sync (
      .i_mclk   (i_mclk),
      .i_arst_n (i_arst_n),
      .i_d      ({i_serial_clock_in, i_serial_data_input, i_latch_reset_strobe,
                  i_pwm_clock_in, i_open_string_sense}),
      .o_q      (pins_s)
   );
   assign {sck_s, sdi_s, strb_s, pck_s, sense_s} = pins_s;
   assign sck_rise  = sck_s & ~sck_prev;
   assign strb_rise = strb_s & ~strb_prev;
   assign pwm_rise  = pck_s & ~pck_prev;

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sck_prev  <= 1'b0;
         strb_prev <= 1'b0;
         pck_prev  <= 1'b0;
      end else begin
         sck_prev  <= sck_s;
         strb_prev <= strb_s;
         pck_prev  <= pck_s;
      end
   end

   // ---------------- Frame port and command state ----------------
   logic [FRAME_BITS-1:0] sr, next_sr, status;
   logic [BITCNT_W-1:0]   bitcnt, next_bitcnt;
   logic [3:0]            cmd_hi, next_cmd_hi;
   logic                  fr_err, next_fr_err, phase, next_phase;
   logic                  bypass, next_bypass, out_en, next_out_en;
   logic                  olt_sel, next_olt_sel, sck_out, next_sck_out;
   logic [BLANK_W-1:0]    blank_cnt, next_blank_cnt;
   logic [TRIM_W-1:0]     trim [CH_NUM];
   logic [TRIM_W-1:0]     next_trim [CH_NUM];
   logic [CH_W-1:0]       staging [CH_NUM];
   logic [CH_W-1:0]       next_staging [CH_NUM];
   logic [CH_W-1:0]       mult [CH_NUM];
   logic [3:0]            cmd_now;
   logic                  soft_rst, en_evt, test_go, upd_sync, upd_async, err_clr;
   logic [CH_NUM-1:0]     open_bits;
   logic                  open_lvl, st_report, hold;

   assign cmd_now   = sr[CMD_W-1:ST_CMD_LSB];
   assign soft_rst  = strb_s && (blank_cnt == BLANK_TOP - 1'b1);
   assign en_evt    = strb_rise && (cmd_now == CMD_OUT_EN) && !out_en;
   assign test_go   = strb_rise && (cmd_now == CMD_SELF_TEST);
   assign upd_sync  = strb_rise && (cmd_now == CMD_UPD_SYNC);
   assign upd_async = strb_rise && (cmd_now == CMD_UPD_ASYNC);
   assign err_clr   = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[0]
                      && (i_wb_adr == REG_STATUS) && i_wb_dat[ST_ERR];
   assign o_serial_data_output = sr[FRAME_BITS-1];
   assign o_serial_clock_out   = sck_out;

   genvar g;
   generate
      for (g = 0; g < CH_NUM; g++) begin : g_mul
         logic [CH_W-1:0]   field;
         logic [PROD_W-1:0] prod, quo;
         assign field = sr[CMD_W + CH_W*g +: CH_W];
         assign prod  = PROD_W'(field) * PROD_W'(7'(trim[g]) + 7'(TRIM_OFS));
         assign quo   = prod / PROD_W'(TRIM_DIV);
         // Quotient cannot exceed 4052, yet clamp keeps the staging width honest
         assign mult[g] = bypass ? field : ((quo > PROD_W'(CNT_MAX)) ? CNT_MAX : quo[CH_W-1:0]);
      end
   endgenerate

   always_comb begin
      status = '0;
      status[CMD_W-1:ST_CMD_LSB] = cmd_hi;
      status[ST_OLT] = olt_sel;
      status[ST_ERR] = fr_err;
      status[ST_PHS] = phase;
      status[ST_BYP] = bypass;
      for (int k = 0; k < CH_NUM; k++) begin
         status[CMD_W + CH_W*k + ST_OPEN] = olt_sel ? open_bits[k] : open_lvl;
         status[CMD_W + CH_W*k + ST_TRIM +: TRIM_W] = trim[k];
      end
   end

   always_comb begin
      next_sr        = sr;
      next_bitcnt    = bitcnt;
      next_cmd_hi    = cmd_hi;
      next_fr_err    = fr_err;
      next_phase     = phase;
      next_bypass    = bypass;
      next_out_en    = out_en;
      next_olt_sel   = olt_sel;
      next_sck_out   = sck_s;
      next_blank_cnt = '0;
      next_trim      = trim;
      next_staging   = staging;
      if (err_clr) begin
         next_fr_err = 1'b0;
      end
      if (sck_rise && !strb_s) begin
         next_sr     = {sr[FRAME_BITS-2:0], sdi_s};
         next_bitcnt = (bitcnt == LAST_BIT) ? '0 : bitcnt + 1'b1;
      end
      if (sck_s && strb_s) begin
         next_fr_err = 1'b1;
      end
      if (strb_s) begin
         next_bitcnt    = '0;
         next_sr        = status;
         next_blank_cnt = (blank_cnt == BLANK_TOP) ? blank_cnt : blank_cnt + 1'b1;
      end
      if (strb_rise) begin
         if (bitcnt != '0) begin
            next_fr_err = 1'b1;
         end
         next_cmd_hi  = cmd_now;
         next_olt_sel = st_report;
         case (cmd_now)
            CMD_UPD_SYNC, CMD_UPD_ASYNC: next_staging = mult;
            CMD_TRIM_LOAD: begin
               for (int k = 0; k < CH_NUM; k++) begin
                  next_trim[k] = sr[CMD_W + CH_W*k +: TRIM_W];
               end
            end
            CMD_OUT_EN:    next_out_en = 1'b1;
            CMD_OUT_DIS:   next_out_en = 1'b0;
            CMD_PHASE_TGL: next_phase  = ~phase;
            CMD_BYP_TGL:   next_bypass = ~bypass;
            default: ;
         endcase
      end
      if (soft_rst) begin
         next_sr      = '0;
         next_bitcnt  = '0;
         next_cmd_hi  = '0;
         next_fr_err  = 1'b0;
         next_phase   = 1'b0;
         next_bypass  = 1'b0;
         next_out_en  = 1'b0;
         next_olt_sel = 1'b0;
         for (int k = 0; k < CH_NUM; k++) begin
            next_trim[k]    = '0;
            next_staging[k] = '0;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sr        <= '0;
         bitcnt    <= '0;
         cmd_hi    <= '0;
         fr_err    <= 1'b0;
         phase     <= 1'b0;
         bypass    <= 1'b0;
         out_en    <= 1'b0;
         olt_sel   <= 1'b0;
         sck_out   <= 1'b0;
         blank_cnt <= '0;
         for (int k = 0; k < CH_NUM; k++) begin
            trim[k]    <= '0;
            staging[k] <= '0;
         end
      end else begin
         sr        <= next_sr;
         bitcnt    <= next_bitcnt;
         cmd_hi    <= next_cmd_hi;
         fr_err    <= next_fr_err;
         phase     <= next_phase;
         bypass    <= next_bypass;
         out_en    <= next_out_en;
         olt_sel   <= next_olt_sel;
         sck_out   <= next_sck_out;
         blank_cnt <= next_blank_cnt;
         trim      <= next_trim;
         staging   <= next_staging;
      end
   end

   // ---------------- PWM timing, self test ----------------
   // Everything below steps on i_mclk, counting sampled PWM clock edges, so active values
   // never cross an asynchronous boundary.
   logic [CH_W-1:0]   cnt, next_cnt;
   logic [CH_W-1:0]   active [CH_NUM];
   logic [CH_W-1:0]   next_active [CH_NUM];
   logic              pend, next_pend, next_open_lvl, next_st_report;
   logic [CH_NUM-1:0] next_pwm, next_open_bits;
   test_state_t       st_state, next_st_state;
   logic [5:0]        st_ch, next_st_ch, st_cnt, next_st_cnt;

   always_comb begin
      next_cnt       = cnt;
      next_active    = active;
      next_pend      = pend;
      next_open_lvl  = open_lvl;
      next_open_bits = open_bits;
      next_st_report = st_report;
      next_st_state  = st_state;
      next_st_ch     = st_ch;
      next_st_cnt    = st_cnt;
      if (pwm_rise) begin
         next_open_lvl = sense_s;
         next_cnt      = cnt + 1'b1;
         if (cnt == CNT_MAX && pend) begin
            next_active = staging;
            next_pend   = 1'b0;
         end
      end
      if (upd_sync) begin
         next_pend = 1'b1;
      end
      if (upd_async) begin
         next_active = mult;
         next_pend   = 1'b0;
      end
      if (en_evt) begin
         next_cnt = '0;
      end
      if (strb_rise) begin
         next_st_report = 1'b0;
      end
      case (st_state)
         ST_IDLE: begin
            if (test_go) begin
               next_st_state = ST_RUN;
               next_st_ch    = '0;
               next_st_cnt   = '0;
            end
         end
         ST_RUN: begin
            if (pwm_rise) begin
               next_st_cnt = st_cnt + 1'b1;
               if (st_cnt == TEST_LAST) begin
                  next_open_bits[st_ch] = sense_s;
                  if (st_ch == LAST_CH) begin
                     next_st_state  = ST_IDLE;
                     next_st_report = 1'b1;
                  end else begin
                     next_st_ch = st_ch + 1'b1;
                  end
               end
            end
         end
         default: next_st_state = ST_IDLE;
      endcase
      for (int k = 0; k < CH_NUM; k++) begin
         if (hold) begin
            next_pwm[k] = 1'b0;
         end else if (st_state == ST_RUN) begin
            next_pwm[k] = (st_ch == 6'(k));
         end else begin
            next_pwm[k] = out_en && (cnt < active[k]);
         end
      end
      if (soft_rst) begin
         next_cnt       = '0;
         next_pend      = 1'b0;
         next_open_bits = '0;
         next_st_report = 1'b0;
         next_st_state  = ST_IDLE;
         next_pwm       = '0;
         for (int k = 0; k < CH_NUM; k++) begin
            next_active[k] = '0;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt       <= '0;
         pend      <= 1'b0;
         open_lvl  <= 1'b0;
         open_bits <= '0;
         st_report <= 1'b0;
         st_state  <= ST_IDLE;
         st_ch     <= '0;
         st_cnt    <= '0;
         o_pwm     <= '0;
         for (int k = 0; k < CH_NUM; k++) begin
            active[k] <= '0;
         end
      end else begin
         cnt       <= next_cnt;
         pend      <= next_pend;
         open_lvl  <= next_open_lvl;
         open_bits <= next_open_bits;
         st_report <= next_st_report;
         st_state  <= next_st_state;
         st_ch     <= next_st_ch;
         st_cnt    <= next_st_cnt;
         o_pwm     <= next_pwm;
         active    <= next_active;
      end
   end

   // ---------------- Wishbone slave, one wait state ----------------
   logic        next_ack, next_hold;
   logic [31:0] next_rdat;

   always_comb begin
      next_ack  = i_wb_cyc && i_wb_stb && !o_wb_ack;
      next_hold = hold;
      next_rdat = '0;
      if (next_ack && i_wb_we && i_wb_sel[0] && i_wb_adr == REG_CTRL) begin
         next_hold = i_wb_dat[CTRL_HOLD];
      end
      if (next_ack && !i_wb_we) begin
         case (i_wb_adr)
            REG_STATUS: begin
               next_rdat[CMD_W-1:0]  = status[CMD_W-1:0];
               next_rdat[RS_OUT_EN]  = out_en;
               next_rdat[RS_TEST]    = (st_state == ST_RUN);
            end
            REG_CTRL:  next_rdat[CTRL_HOLD] = hold;
            REG_COUNT: next_rdat[CH_W-1:0]  = cnt;
            default:   next_rdat = '0;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= '0;
         hold     <= 1'b0;
      end else begin
         o_wb_ack <= next_ack;
         o_wb_dat <= next_rdat;
         hold     <= next_hold;
      end
   end

   // ---------------- Checks ----------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);

   shift_entry_a: assert property (sck_rise && !strb_s |=> sr[0] == $past(sdi_s))
      else $error("shift register did not take data input");
   pwm_compare_a: assert property (out_en && !hold && st_state == ST_IDLE && !soft_rst
      |=> o_pwm[0] == ($past(cnt) < $past(active[0])))
      else $error("channel output disagrees with counter compare");
   counter_wrap_a: assert property (pwm_rise && cnt == CNT_MAX && !soft_rst |=> cnt == '0)
      else $error("PWM counter did not wrap to zero");
   blank_reset_a: assert property (soft_rst |=> o_pwm == '0 && !out_en && sr == '0)
      else $error("long strobe did not reset the chip");
   async_update_a: assert property (upd_async && !soft_rst |=> active[0] == staging[0])
      else $error("async update did not reach active latch");
   sync_update_a: assert property (pend && pwm_rise && cnt == CNT_MAX && !strb_rise && !soft_rst
      |=> active[0] == $past(staging[0]))
      else $error("sync update missed period start");
   outputs_off_a: assert property (!out_en && st_state == ST_IDLE |=> o_pwm == '0)
      else $error("output active while disabled");
   framing_err_a: assert property (strb_rise && bitcnt != '0 && !soft_rst |=> fr_err)
      else $error("off-boundary strobe not flagged");
   frame_start_a: assert property (strb_s ##1 !strb_s |-> bitcnt == '0)
      else $error("bit counter not restarted by strobe");
   enable_align_a: assert property (en_evt && !soft_rst |=> cnt == '0 && out_en)
      else $error("enable did not restart the period");
   bypass_tgl_a: assert property (strb_rise && cmd_now == CMD_BYP_TGL && !soft_rst
      |=> bypass != $past(bypass))
      else $error("bypass flag not toggled");

   cover_async_c: cover property (upd_async ##[1:1000] pwm_rise);
   cover_test_c:  cover property (st_state == ST_RUN ##1 st_state == ST_IDLE);
   cover_blank_c: cover property (soft_rst);
   cover_err_c:   cover property (strb_rise && bitcnt != '0);
endmodule

/* File: rtl/pwm_bank_pkg.sv */
// Constants, command codes and field layouts of the 48-channel serial PWM bank.
// Assumes one system clock of 25 MHz; all pin inputs are sampled by that clock.
package pwm_bank_pkg;
   localparam int CH_NUM     = 48;
   localparam int CH_W       = 12;
   localparam int CMD_W      = 8;
   localparam int TRIM_W     = 6;
   localparam int FRAME_BITS = CH_NUM * CH_W + CMD_W;
   localparam int BITCNT_W   = 10;
   localparam int PIN_NUM    = 5;

   // Trim scaling: x * 2/3 * (t + 32) / 64 == x * (t + 32) / 96
   localparam int TRIM_OFS   = 32;
   localparam int TRIM_DIV   = 64 * 3 / 2;
   localparam int PROD_W     = 19;
   localparam int TEST_PULSE = 64;

   localparam int MCLK_NS    = 40;
   localparam int BLANK_NS   = 50000;
   localparam int BLANK_CYC  = (BLANK_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int BLANK_W    = 11;

   // Upper nibble of the command field
   localparam logic [3:0] CMD_UPD_SYNC  = 4'h0;
   localparam logic [3:0] CMD_UPD_ASYNC = 4'h1;
   localparam logic [3:0] CMD_TRIM_LOAD = 4'h2;
   localparam logic [3:0] CMD_OUT_EN    = 4'h3;
   localparam logic [3:0] CMD_OUT_DIS   = 4'h4;
   localparam logic [3:0] CMD_SELF_TEST = 4'h5;
   localparam logic [3:0] CMD_PHASE_TGL = 4'h6;
   localparam logic [3:0] CMD_BYP_TGL   = 4'h7;

   // Status frame: command field bit positions
   localparam int ST_CMD_LSB = 4;
   localparam int ST_OLT     = 3;
   localparam int ST_ERR     = 2;
   localparam int ST_PHS     = 1;
   localparam int ST_BYP     = 0;
   // Status frame: channel field bit positions
   localparam int ST_OPEN    = 0;
   localparam int ST_TRIM    = 1;

   // Wishbone register map (byte addresses)
   localparam int ADR_W = 4;
   localparam logic [ADR_W-1:0] REG_STATUS = 4'h0;
   localparam logic [ADR_W-1:0] REG_CTRL   = 4'h4;
   localparam logic [ADR_W-1:0] REG_COUNT  = 4'h8;
   localparam int RS_OUT_EN  = 8;
   localparam int RS_TEST    = 9;
   localparam int CTRL_HOLD  = 0;

   typedef enum logic {ST_IDLE, ST_RUN} test_state_t;
endpackage

/* File: rtl/pin_sync.sv */
// Two-flop synchroniser for a group of unrelated single-bit pin inputs.
// Assumes each bit is independent; no word coherence is implied.
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         i_mclk,
   input  wire logic         i_arst_n,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta;

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta <= '0;
         o_q  <= '0;
      end else begin
         meta <= i_d;
         o_q  <= meta;
      end
   end
endmodule

/* File: testbench/host_model.sv */
// Host controller model for the serial frame port: sends frames, collects status.
// Assumes i_mclk at 25 MHz; one serial bit takes 8 mclk (320 ns), clock idle low.
`timescale 1ns/10ps
module host_model (
   input  wire logic i_mclk,
   input  wire logic i_sdo,
   input  wire logic i_serial_clock_out,
   output logic      o_sck,
   output logic      o_sdi,
   output logic      o_stb
);
   logic [583:0] rx;
   int           serial_clock_out_err = 0;

   initial begin
      o_sck = 1'b0;
      o_sdi = 1'b0;
      o_stb = 1'b0;
   end

   // A short count sends only the low bits, so the command still lands last
   task automatic send(input int nbits, input logic [11:0] fld, input logic [7:0] cmd);
      logic [583:0] tx;
      tx = {{48{fld}}, cmd};
      for (int i = nbits - 1; i >= 0; i--) begin
         @(posedge i_mclk) o_sdi <= tx[i];
         repeat (3) @(posedge i_mclk);
         rx[i] = i_sdo;
         if (i_serial_clock_out !== 1'b0) begin
            serial_clock_out_err++;
         end
         o_sck <= 1'b1;
         repeat (4) @(posedge i_mclk);
         // Forwarded clock lags by the sampler, so it is high by now
         if (i_serial_clock_out !== 1'b1) begin
            serial_clock_out_err++;
         end
         o_sck <= 1'b0;
      end
      repeat (4) @(posedge i_mclk);
      // Released data line shows the inverse, never a stale copy
      o_sdi <= ~o_sdi;
      o_stb <= 1'b1;
      repeat (8) @(posedge i_mclk);
      o_stb <= 1'b0;
      repeat (4) @(posedge i_mclk);
   endtask

   // Held well past the 1250-cycle blank time
   task automatic blank();
      @(posedge i_mclk) o_stb <= 1'b1;
      repeat (1300) @(posedge i_mclk);
      o_stb <= 1'b0;
      repeat (8) @(posedge i_mclk);
   endtask
endmodule

/* File: testbench/serial_framed_pwm_bank48_bench.sv */
// Self-checking bench: frames from the host model, registers over Wishbone.
// Assumes the design samples every pin with i_mclk; PWM clock pulsed by hand.
`timescale 1ns/10ps
module serial_framed_pwm_bank48_bench;
   import pwm_bank_pkg::*;
   localparam logic [47:0] ALL = {48{1'b1}};
   logic        i_mclk   = 1'b0;
   logic        i_arst_n = 1'b0;
   logic        pwm_ck   = 1'b0;
   logic        cyc      = 1'b0;
   logic        wstb     = 1'b0;
   logic        we       = 1'b0;
   logic [3:0]  adr      = 4'h0;
   logic [31:0] wdat     = 32'h0;
   logic [31:0] rd_val;
   logic        sck, serial_data_input, stb, serial_data_output, ack;
   logic        serial_clock_out;
   logic        sense    = 1'b1;
   logic [47:0] pwm;
   logic [31:0] wb_rd;
   int          error_cnt  = 0;
   int          num_checks = 0;

   always #20 i_mclk = ~i_mclk;

   serial_framed_pwm_bank48 u_dut (
      .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_serial_clock_in(sck),
      .i_serial_data_input(serial_data_input), .i_latch_reset_strobe(stb), .i_pwm_clock_in(pwm_ck),
      .i_open_string_sense(sense), .o_serial_clock_out(serial_clock_out), .o_serial_data_output(serial_data_output),
      .o_pwm(pwm), .i_wb_cyc(cyc), .i_wb_stb(wstb), .i_wb_we(we), .i_wb_adr(adr),
      .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(wb_rd), .o_wb_ack(ack)
   );

   host_model u_host (.i_mclk(i_mclk), .i_sdo(serial_data_output), .i_serial_clock_out(serial_clock_out), .o_sck(sck), .o_sdi(serial_data_input), .o_stb(stb));

   task automatic stop_test();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Registered outputs read right after an edge still hold their sampled value
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_mclk);
      cyc  <= 1'b1;
      wstb <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge i_mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd_val = wb_rd;
      cyc  <= 1'b0;
      wstb <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         stop_test();
      end
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk({16'h0, rd_val}, {16'h0, exp});
   endtask

   // Period of 6 mclk keeps the PWM clock below a quarter of mclk
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge i_mclk) pwm_ck <= 1'b1;
         repeat (3) @(posedge i_mclk);
         pwm_ck <= 1'b0;
         repeat (2) @(posedge i_mclk);
      end
      repeat (4) @(posedge i_mclk);
   endtask

   initial begin
      repeat (12) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      repeat (4) @(posedge i_mclk);
      chk(pwm, 48'h0);
      chk({47'h0, serial_data_output}, 48'h0);
      rd(REG_STATUS, 32'h0);
      wb(1'b1, 4'hc, 32'hff);
      rd(4'hc, 32'h0);
      // Sense level is only captured on PWM clock rises
      pulse(1);
      u_host.send(584, 12'd63, 8'h20);
      rd(REG_STATUS, 32'h20);
      u_host.send(584, 12'd12, 8'h10);
      chk({28'h0, u_host.rx[583:572], u_host.rx[7:0]}, {28'h0, 12'h07f, 8'h20});
      u_host.send(584, 12'd0, 8'h30);
      chk(pwm, ALL);
      pulse(10);
      chk(pwm, ALL);
      pulse(1);
      chk(pwm, 48'h0);
      rd(REG_COUNT, 32'd11);
      u_host.send(584, 12'd0, 8'h70);
      rd(REG_STATUS, 32'h171);
      u_host.send(584, 12'd12, 8'h10);
      chk(pwm, ALL);
      pulse(1);
      chk(pwm, 48'h0);
      u_host.send(584, 12'd100, 8'h00);
      chk(pwm, 48'h0);
      pulse(4083);
      chk(pwm, 48'h0);
      // Open string from here on: next status frame reports a low sense
      sense <= 1'b0;
      pulse(1);
      chk(pwm, ALL);
      u_host.send(583, 12'd0, 8'h60);
      rd(REG_STATUS, 32'h167);
      wb(1'b1, REG_STATUS, 32'h4);
      rd(REG_STATUS, 32'h163);
      u_host.send(584, 12'd0, 8'h40);
      chk({28'h0, u_host.rx[583:572], u_host.rx[7:0]}, {28'h0, 12'h07e, 8'h67});
      chk(pwm, 48'h0);
      u_host.send(584, 12'd0, 8'h50);
      chk(pwm, 48'h1);
      rd(REG_STATUS, 32'h253);
      pulse(64);
      chk(pwm, 48'h2);
      u_host.blank();
      chk(pwm, 48'h0);
      rd(REG_STATUS, 32'h0);
      chk({16'h0, u_host.serial_clock_out_err}, 48'h0);
      stop_test();
   end

   initial begin
      repeat (90000) @(posedge i_mclk);
      error_cnt++;
      stop_test();
   end
endmodule
